// ==== hw/pll_fb_cfg_regs.sv ====
// APB register bank for the fractional-N feedback path of a clock synthesizer.
// Assumes an APB3 master on pclk; field outputs feed the analog PLL directly.
//
// Summary of operation
// [RQ1] An RW byte holds integer divide bits 7:0 and resets to 0x66.
// [RQ2] The 22-bit numerator is high[5:0], mid and low bytes, top to bottom.
// [RQ3] The 22-bit denominator is assembled from three bytes the same way.
// [RQ4] All numerator and denominator bytes reset to zero and are RW.
// [RQ5] Dither select sits in bits 3:2, resets to 3, and 3 means no dither.
// [RQ6] Order select sits in bits 1:0, resets to 0, and 0 is integer mode.
// [RQ7] The R2 code sits in bits 5:0, resets to 0x24, and any code is legal.
// [RQ8] The C1 code sits in bits 2:0, resets to 0, giving 5 + 50*code pF.
// [RQ9] Reserved bits read as zero and writes to them change nothing.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "pll_fb_cfg_consts.svh"
module pll_fb_cfg_regs
  import pll_fb_cfg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] feedback_int_divide_value,
  output logic [21:0] frac_numerator_value,
  output logic [21:0] frac_denominator_value,
  output dither_mode_t modulator_dither_select,
  output mod_order_t modulator_order_select,
  output logic [5:0] filter_resistor_two_code,
  output logic [2:0] filter_cap_one_code,
  output logic [8:0] filter_cap_one_pf,
  output logic dither_enabled,
  output logic integer_mode,
  output logic frac_den_zero,
  output logic cfg_update
);

  // Register select positions within the decoder's one-hot vector
  localparam int S_INT = 0;
  localparam int S_NUM_H = 1;
  localparam int S_NUM_M = 2;
  localparam int S_NUM_L = 3;
  localparam int S_DEN_H = 4;
  localparam int S_DEN_M = 5;
  localparam int S_DEN_L = 6;
  localparam int S_MOD = 7;
  localparam int S_R2 = 8;
  localparam int S_C1 = 9;

  logic [`NUM_REGS-1:0] sel;
  logic hit;
  bus_phase_t phase;
  bus_phase_t next_phase;
  logic access;
  logic write_commit;
  logic [`NUM_REGS-1:0] wr_en;
  logic [7:0] wbyte;

  logic [7:0] int_low_q;
  logic [5:0] num_high_q;
  logic [7:0] num_mid_q;
  logic [7:0] num_low_q;
  logic [5:0] den_high_q;
  logic [7:0] den_mid_q;
  logic [7:0] den_low_q;
  logic [3:0] mod_ctrl_q;
  logic [5:0] r2_q;
  logic [2:0] c1_q;

  logic [7:0] rd_int;
  logic [7:0] rd_num_h;
  logic [7:0] rd_num_m;
  logic [7:0] rd_num_l;
  logic [7:0] rd_den_h;
  logic [7:0] rd_den_m;
  logic [7:0] rd_den_l;
  logic [7:0] rd_mod;
  logic [7:0] rd_r2;
  logic [7:0] rd_c1;
  logic [7:0] read_byte;
  logic [31:0] next_prdata;
  logic [8:0] next_cap_pf;
  logic [21:0] next_den;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_rd_word;
  logic next_dither_en;
  logic next_int_mode;
  logic next_den_zero;
  logic next_update;

  cfg_addr_decode u_decode (
    .paddr(paddr),
    .sel(sel),
    .hit(hit)
  );

  // Access phase: first cycle waits, the pready cycle commits
  assign access = psel && penable;
  assign next_phase = (access && phase == BUS_SETUP) ? BUS_ANSWER : BUS_SETUP;
  assign write_commit = access && pready && pwrite;
  assign wr_en = write_commit ? sel : '0;
  assign wbyte = pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= BUS_SETUP;
    end else begin
      phase <= next_phase;
    end
  end

  cfg_field_reg #(
    .W(8),
    .RESET(`RST_INT_DIVIDER_LOW)
  ) u_int_low ( // [RQ1]
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en[S_INT]),
    .wr_data(wbyte),
    .q(int_low_q)
  );

  cfg_field_reg #(
    .W(`FRAC_HIGH_W),
    .RESET(`RST_FRAC_HIGH)
  ) u_num_high ( // [RQ2] [RQ4] [RQ9]
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en[S_NUM_H]),
    .wr_data(wbyte[`FRAC_HIGH_W-1:0]),
    .q(num_high_q)
  );

  cfg_field_reg #(
    .W(8),
    .RESET(`RST_FRAC_BYTE)
  ) u_num_mid ( // [RQ4]
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en[S_NUM_M]),
    .wr_data(wbyte),
    .q(num_mid_q)
  );

  cfg_field_reg #(
    .W(8),
    .RESET(`RST_FRAC_BYTE)
  ) u_num_low ( // [RQ4]
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en[S_NUM_L]),
    .wr_data(wbyte),
    .q(num_low_q)
  );

  cfg_field_reg #(
    .W(`FRAC_HIGH_W),
    .RESET(`RST_FRAC_HIGH)
  ) u_den_high ( // [RQ3] [RQ4] [RQ9]
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en[S_DEN_H]),
    .wr_data(wbyte[`FRAC_HIGH_W-1:0]),
    .q(den_high_q)
  );

  cfg_field_reg #(
    .W(8),
    .RESET(`RST_FRAC_BYTE)
  ) u_den_mid ( // [RQ4]
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en[S_DEN_M]),
    .wr_data(wbyte),
    .q(den_mid_q)
  );

  cfg_field_reg #(
    .W(8),
    .RESET(`RST_FRAC_BYTE)
  ) u_den_low ( // [RQ4]
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en[S_DEN_L]),
    .wr_data(wbyte),
    .q(den_low_q)
  );

  cfg_field_reg #(
    .W(`MOD_CTRL_W),
    .RESET(`RST_MOD_CTRL)
  ) u_mod_ctrl ( // [RQ5] [RQ6] [RQ9]
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en[S_MOD]),
    .wr_data(wbyte[`MOD_CTRL_W-1:0]),
    .q(mod_ctrl_q)
  );

  cfg_field_reg #(
    .W(`R2_W),
    .RESET(`RST_R2)
  ) u_r2 ( // [RQ7] [RQ9]
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en[S_R2]),
    .wr_data(wbyte[`R2_W-1:0]),
    .q(r2_q)
  );

  cfg_field_reg #(
    .W(`C1_W),
    .RESET(`RST_C1)
  ) u_c1 ( // [RQ8] [RQ9]
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en[S_C1]),
    .wr_data(wbyte[`C1_W-1:0]),
    .q(c1_q)
  );

  // Field outputs come straight from the field flops
  assign feedback_int_divide_value = int_low_q; // [RQ1]
  assign frac_numerator_value = {num_high_q, num_mid_q, num_low_q}; // [RQ2]
  assign frac_denominator_value = {den_high_q, den_mid_q, den_low_q}; // [RQ3]
  assign modulator_dither_select =
    dither_mode_t'(mod_ctrl_q[`DITHER_MSB:`DITHER_LSB]); // [RQ5]
  assign modulator_order_select =
    mod_order_t'(mod_ctrl_q[`ORDER_MSB:`ORDER_LSB]); // [RQ6]
  assign filter_resistor_two_code = r2_q; // [RQ7]
  assign filter_cap_one_code = c1_q; // [RQ8]

  // Read-back with reserved bits forced to zero
  assign rd_int = int_low_q;
  assign rd_num_h = {2'h0, num_high_q}; // [RQ9]
  assign rd_num_m = num_mid_q;
  assign rd_num_l = num_low_q;
  assign rd_den_h = {2'h0, den_high_q}; // [RQ9]
  assign rd_den_m = den_mid_q;
  assign rd_den_l = den_low_q;
  assign rd_mod = {4'h0, mod_ctrl_q}; // [RQ9]
  assign rd_r2 = {2'h0, r2_q}; // [RQ9]
  assign rd_c1 = {5'h0, c1_q}; // [RQ9]

  assign read_byte = ({8{sel[S_INT]}} & rd_int)
                   | ({8{sel[S_NUM_H]}} & rd_num_h)
                   | ({8{sel[S_NUM_M]}} & rd_num_m)
                   | ({8{sel[S_NUM_L]}} & rd_num_l)
                   | ({8{sel[S_DEN_H]}} & rd_den_h)
                   | ({8{sel[S_DEN_M]}} & rd_den_m)
                   | ({8{sel[S_DEN_L]}} & rd_den_l)
                   | ({8{sel[S_MOD]}} & rd_mod)
                   | ({8{sel[S_R2]}} & rd_r2)
                   | ({8{sel[S_C1]}} & rd_c1);
  assign next_prdata = {24'h0000_00, read_byte};

  // Answer one cycle into the access phase
  assign next_pready = (next_phase == BUS_ANSWER);
  assign next_pslverr = next_pready && !hit;
  assign next_rd_word = (next_pready && !pwrite) ? next_prdata
                                                 : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= next_pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= next_pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_rd_word;
    end
  end

  // Status derived from the stored fields and the write enables, registered
  // Each status flag lags its field by one cycle; cfg_update lags the write enables and rises with the written field
  assign next_cap_pf = `C1_BASE_PF + `C1_STEP_PF * {6'h00, c1_q}; // [RQ8]
  assign next_den = {den_high_q, den_mid_q, den_low_q};
  assign next_dither_en = (modulator_dither_select != DITHER_OFF); // [RQ5]
  assign next_int_mode = (modulator_order_select == ORDER_INTEGER); // [RQ6]
  assign next_den_zero = (next_den == 22'h00_0000);
  assign next_update = |wr_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_cap_one_pf <= `C1_BASE_PF;
    end else begin
      filter_cap_one_pf <= next_cap_pf;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dither_enabled <= 1'b0;
    end else begin
      dither_enabled <= next_dither_en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      integer_mode <= 1'b1;
    end else begin
      integer_mode <= next_int_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frac_den_zero <= 1'b1;
    end else begin
      frac_den_zero <= next_den_zero;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_update <= 1'b0;
    end else begin
      cfg_update <= next_update;
    end
  end

endmodule : pll_fb_cfg_regs

// ==== hw/pll_fb_cfg_consts.svh ====
// Register map, reset values and field layout of the feedback divider bank.
// Assumes inclusion by bare name from the design files.
`ifndef PLL_FB_CFG_CONSTS_SVH
`define PLL_FB_CFG_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_INT_DIVIDER_LOW_BYTE 10'h03b
`define IDX_FRAC_NUMERATOR_HIGH 10'h03c
`define IDX_FRAC_NUMERATOR_MID 10'h03d
`define IDX_FRAC_NUMERATOR_LOW 10'h03e
`define IDX_FRAC_DENOMINATOR_HIGH 10'h03f
`define IDX_FRAC_DENOMINATOR_MID 10'h040
`define IDX_FRAC_DENOMINATOR_LOW 10'h041
`define IDX_MODULATOR_CONTROL 10'h042
`define IDX_LOOP_FILTER_RESISTOR_TWO 10'h043
`define IDX_LOOP_FILTER_CAP_ONE 10'h044
`define NUM_REGS 10

// Field positions
`define DITHER_MSB 3
`define DITHER_LSB 2
`define ORDER_MSB 1
`define ORDER_LSB 0
`define FRAC_HIGH_W 6
`define MOD_CTRL_W 4
`define R2_W 6
`define C1_W 3

// Reset values
`define RST_INT_DIVIDER_LOW 8'h66
`define RST_FRAC_BYTE 8'h00
`define RST_FRAC_HIGH 6'h00
`define RST_MOD_CTRL 4'hc
`define RST_R2 6'h24
`define RST_C1 3'h0

// C1 capacitance: base plus step times code, in pF
`define C1_BASE_PF 9'h005
`define C1_STEP_PF 9'h032

`endif

// ==== hw/pll_fb_cfg_pkg.sv ====
// Types shared by the feedback divider configuration bank.
// Assumes nothing beyond a SystemVerilog compiler.
package pll_fb_cfg_pkg;

  typedef enum logic [1:0] {
    DITHER_WEAK = 2'b00,
    DITHER_MEDIUM = 2'b01,
    DITHER_STRONG = 2'b10,
    DITHER_OFF = 2'b11
  } dither_mode_t;

  typedef enum logic [1:0] {
    ORDER_INTEGER = 2'b00,
    ORDER_FIRST = 2'b01,
    ORDER_SECOND = 2'b10,
    ORDER_THIRD = 2'b11
  } mod_order_t;

  typedef enum logic [1:0] {
    BUS_SETUP = 2'b00,
    BUS_ANSWER = 2'b01
  } bus_phase_t;

endpackage : pll_fb_cfg_pkg

// ==== hw/cfg_field_reg.sv ====
// One software-writable configuration field with a fixed reset value.
// Assumes write enable and data come from logic on the same clock.
`timescale 1ns/1ps
module cfg_field_reg #(
  parameter int W = 8,
  parameter logic [W-1:0] RESET = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  output logic [W-1:0] q
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RESET;
    end else if (wr_en) begin
      q <= wr_data;
    end
  end

endmodule : cfg_field_reg

// ==== hw/cfg_addr_decode.sv ====
// Turns an APB byte address into one-hot register selects.
// Assumes word-aligned registers in one contiguous index range.
`timescale 1ns/1ps
`include "pll_fb_cfg_consts.svh"
module cfg_addr_decode (
  input wire logic [11:0] paddr,
  output logic [`NUM_REGS-1:0] sel,
  output logic hit
);

  logic [9:0] index;
  logic aligned;
  logic [9:0] offset;
  logic in_range;

  assign index = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign offset = index - `IDX_INT_DIVIDER_LOW_BYTE;
  assign in_range = (index >= `IDX_INT_DIVIDER_LOW_BYTE) &&
                    (index <= `IDX_LOOP_FILTER_CAP_ONE);
  assign hit = aligned && in_range;

  genvar i;
  generate
    for (i = 0; i < `NUM_REGS; i++) begin : g_sel
      assign sel[i] = hit && (offset == 10'(i));
    end
  endgenerate

endmodule : cfg_addr_decode

// ==== tb/pll_fb_cfg_checker.sv ====
// Concurrent checks on the feedback divider register bank ports.
// Bound to pll_fb_cfg_regs; single pclk domain, async low reset.
`timescale 1ns/1ps
module pll_fb_cfg_checker
  import pll_fb_cfg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] feedback_int_divide_value,
  input wire logic [21:0] frac_numerator_value,
  input wire logic [21:0] frac_denominator_value,
  input wire dither_mode_t modulator_dither_select,
  input wire mod_order_t modulator_order_select,
  input wire logic [2:0] filter_cap_one_code,
  input wire logic [8:0] filter_cap_one_pf
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pready && pwrite && !pslverr;
  property p_ready_lat; $rose(psel && penable) |=> pready; endproperty
  a_ready_lat: assert property (p_ready_lat) else $error("pready late");
  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready long");
  property p_rd_idle; !pready |-> prdata == '0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("prdata not idle");
  property p_rd_upper; prdata[31:8] == '0; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper bits");
  property p_int_wr;
    wr && paddr == 12'h0EC |=>
      feedback_int_divide_value == $past(pwdata[7:0]);
  endproperty
  a_int_wr: assert property (p_int_wr) else $error("int divide");
  property p_num_wr;
    wr && paddr == 12'h0F0 |=> frac_numerator_value ==
      {$past(pwdata[5:0]), $past(frac_numerator_value[15:0])};
  endproperty
  a_num_wr: assert property (p_num_wr) else $error("num high");
  property p_den_wr;
    wr && paddr == 12'h104 |=> frac_denominator_value ==
      {$past(frac_denominator_value[21:8]), $past(pwdata[7:0])};
  endproperty
  a_den_wr: assert property (p_den_wr) else $error("den low");
  property p_mod_wr;
    wr && paddr == 12'h108 |=> {modulator_dither_select,
      modulator_order_select} == $past(pwdata[3:0]);
  endproperty
  a_mod_wr: assert property (p_mod_wr) else $error("mod ctrl");
  property p_cap_pf;
    filter_cap_one_pf == 9'h005 + 9'h032 * $past(filter_cap_one_code);
  endproperty
  a_cap_pf: assert property (p_cap_pf) else $error("cap pf");
  c_wr: cover property (wr);
  c_err: cover property (pready && pslverr);
  c_rd: cover property (pready && !pwrite);
endmodule : pll_fb_cfg_checker

bind pll_fb_cfg_regs pll_fb_cfg_checker pll_fb_cfg_checker_inst (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
  .pready, .pslverr, .feedback_int_divide_value, .frac_numerator_value,
  .frac_denominator_value, .modulator_dither_select,
  .modulator_order_select, .filter_cap_one_code, .filter_cap_one_pf
);

// ==== tb/testbench.sv ====
// Self-checking bench for the feedback divider register bank.
// Drives APB itself; expectations come from a shadow table.
`timescale 1ns/1ps
`include "pll_fb_cfg_consts.svh"
module testbench import pll_fb_cfg_pkg::*;;
  logic pclk = 0;
  logic presetn = 0;
  logic [11:0] paddr = '0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] feedback_int_divide_value;
  logic [21:0] frac_numerator_value;
  logic [21:0] frac_denominator_value;
  dither_mode_t modulator_dither_select;
  mod_order_t modulator_order_select;
  logic [5:0] filter_resistor_two_code;
  logic [2:0] filter_cap_one_code;
  logic [8:0] filter_cap_one_pf;
  logic dither_enabled;
  logic integer_mode;
  logic frac_den_zero;
  logic cfg_update;
  logic upd;
  logic [31:0] rd;
  logic [31:0] err;
  localparam logic [31:0] OK_RESP = 0;
  localparam logic [31:0] ERR_RESP = 1;
  int error_cnt = 0;
  int check_count = 0;
  int seed = 74726;
  int idx;
  logic [7:0] shadow [10];
  logic [7:0] mask [10] = '{8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h3F, 8'hFF,
    8'hFF, 8'h0F, 8'h3F, 8'h07};
  logic [7:0] rst [10] = '{8'h66, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h0C, 8'h24, 8'h00};

  pll_fb_cfg_regs pll_fb_cfg_regs_inst (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .feedback_int_divide_value, .frac_numerator_value,
    .frac_denominator_value, .modulator_dither_select,
    .modulator_order_select, .filter_resistor_two_code,
    .filter_cap_one_code, .filter_cap_one_pf, .dither_enabled,
    .integer_mode, .frac_den_zero, .cfg_update
  );

  initial begin
    forever #20 pclk = ~pclk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Sampled at the rising edge, before that edge's updates land
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = 32'(pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    upd = cfg_update;
  endtask : apb

  function logic [11:0] addr(input int i);
    return {`IDX_INT_DIVIDER_LOW_BYTE + 10'(i), 2'b00};
  endfunction : addr

  function logic [21:0] frac(input int b);
    return {shadow[b][5:0], shadow[b+1], shadow[b+2]};
  endfunction : frac

  task wr(input int i, input logic [31:0] d);
    apb(addr(i), 1'b1, d);
    shadow[i] = d[7:0] & mask[i];
    chk(err, OK_RESP);
    chk(32'(upd), 32'h0000_0001);
  endtask : wr

  task check_all();
    for (int i = 0; i < 10; i++) begin
      apb(addr(i), 1'b0, 32'hFFFF_FFFF);
      chk(rd, 32'(shadow[i]));
    end
    chk(32'(feedback_int_divide_value), 32'(shadow[0]));
    chk(32'(frac_numerator_value), 32'(frac(1)));
    chk(32'(frac_denominator_value), 32'(frac(4)));
    chk(32'(modulator_dither_select), 32'(shadow[7][3:2]));
    chk(32'(modulator_order_select), 32'(shadow[7][1:0]));
    chk(32'(filter_resistor_two_code), 32'(shadow[8]));
    chk(32'(filter_cap_one_pf), 5 + 50 * shadow[9][2:0]);
    chk(32'(filter_cap_one_code), 32'(shadow[9][2:0]));
    chk(32'(dither_enabled), 32'(shadow[7][3:2] != 2'h3));
    chk(32'(integer_mode), 32'(shadow[7][1:0] == 2'h0));
    chk(32'(frac_den_zero), 32'(frac(4) == 22'h00_0000));
  endtask : check_all

  task reset_dut();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    shadow = rst;
    check_all();
  endtask : reset_dut

  task finish_test();
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  initial begin
    #(40 * 20000);
    error_cnt++;
    finish_test();
  end

  initial begin
    reset_dut();
    for (int i = 0; i < 16; i++) begin
      wr(7, 32'hFFFF_FFF0 | i);
      check_all();
    end
    for (int i = 0; i < 8; i++) begin
      wr(9, 32'hFFFF_FFF8 | i);
      check_all();
    end
    wr(8, 32'h0000_0030);
    check_all();
    for (int i = 0; i < 40; i++) begin
      idx = $unsigned($random(seed)) % 10;
      wr(idx, $random(seed));
      check_all();
    end
    apb(12'h0E8, 1'b1, 32'hFFFF_FFFF);
    chk(err, ERR_RESP);
    chk(32'(upd), 32'h0000_0000);
    apb(12'h0ED, 1'b1, 32'h0000_0000);
    chk(err, ERR_RESP);
    chk(32'(upd), 32'h0000_0000);
    apb(12'h0E8, 1'b0, 32'h0000_0000);
    chk(err, ERR_RESP);
    chk(rd, OK_RESP);
    check_all();
    reset_dut();
    finish_test();
  end
endmodule : testbench
